// *** rtl/lapd_defs.svh ***
/*
  Control-field codes, register map and reset values for the link control block.
  Assumes inclusion by bare name from the package and the testbench.
*/
`ifndef LAPD_DEFS_SVH
`define LAPD_DEFS_SVH

`define CF_RR 8'h01
`define CF_RNR 8'h05
`define CF_REJ 8'h09
`define CF_SABME 8'h6F
`define CF_DM 8'h0F
`define CF_UI 8'h03
`define CF_DISC 8'h43
`define CF_UA 8'h63
`define CF_FRMR 8'h87
`define CF_XID 8'hAF
`define CF_PF_MASK 8'hEF
`define PF_BIT 4
`define PF_SET 8'h10

`define REG_CTRL 8'h00
`define REG_WINDOW 8'h04
`define REG_STATUS 8'h08
`define REG_VARS 8'h0C
`define REG_EVENTS 8'h10

`define CTRL_SABME 0
`define CTRL_DISC 1
`define CTRL_IFRAME 2
`define CTRL_UI 3
`define CTRL_BUSY 4
`define WINDOW_RESET 7'h07
`define EVT_WIDTH 6

`endif

// *** rtl/lapd_frame_control.sv ***
/*
  Control-field engine of a modulo 128 data link entity: classifies received
  control fields, keeps V(S), V(A), V(R), the link mode and exception conditions,
  and queues one outgoing control field at a time.
  Assumes framing, address, FCS and info fields are handled outside; rx inputs
  come from logic on ref_clk and rxValid is a one-cycle pulse per frame.
*/
`timescale 1ns/1ns
module lapd_frame_control import lapd_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic rxValid,
  input wire logic [7:0] rxOctet4,
  input wire logic [7:0] rxOctet5,
  input wire logic rxCommand,
  input wire logic rxHasInfo,
  input wire logic rxAppKnown,
  input wire logic rxErrorFree,
  output logic txValid,
  output logic [7:0] txOctet4,
  output logic [7:0] txOctet5,
  output logic txTwoOctet,
  output logic txCommand,
  input wire logic txReady,
  output logic iDeliver
);

  seq_t vs;
  seq_t va;
  seq_t vr;
  seq_t rejNr;
  seq_t kWin;
  link_mode_t mode;
  logic peerBusy, rejCond, busyRep, ownBusy;
  logic uaPend, uaF, ackPend, ackF, rejPend;
  logic sabmeReq, discReq, iReq, uiReq;
  logic [`EVT_WIDTH-1:0] evt;
  tx_kind_t nextKind;

  // Receive decode
  logic go, up, isI, isS, uKnown, undef, pf, nrOk;
  logic sSabme, sDisc, uUa, uDm, uUi, uXid, uFrmr;
  logic iAccept, iOutSeq, sValid, nrBad;
  logic [7:0] uKey;
  seq_t nr, ns, nrOff, outOff;
  logic busWr, wrCtrl, canLoad;

  assign go = rxValid & rxAppKnown;
  assign up = (mode == LINK_UP);
  assign uKey = rxOctet4 & `CF_PF_MASK;
  assign pf = rxOctet4[`PF_BIT];
  assign nr = rxOctet5[7:1];
  assign ns = rxOctet4[7:1];
  assign isI = ~rxOctet4[0];
  assign isS = (rxOctet4 == `CF_RR) | (rxOctet4 == `CF_RNR) | (rxOctet4 == `CF_REJ);
  assign sSabme = (uKey == `CF_SABME) & rxCommand & ~rxHasInfo;
  assign sDisc = (uKey == `CF_DISC) & rxCommand & ~rxHasInfo;
  assign uUa = (uKey == `CF_UA) & ~rxCommand;
  assign uDm = (uKey == `CF_DM) & ~rxCommand;
  assign uUi = (uKey == `CF_UI) & rxCommand;
  assign uXid = (uKey == `CF_XID);
  assign uFrmr = (uKey == `CF_FRMR) & ~rxCommand;
  assign uKnown = sSabme | sDisc | uUa | uDm | uUi | uXid | uFrmr;
  assign undef = go & ~isI & ~isS & ~uKnown;
  assign nrOff = nr - va;
  assign outOff = vs - va;
  assign nrOk = (nrOff <= outOff);
  // numbered frames only count while the link is up
  assign sValid = go & up & (isI | isS) & nrOk;
  assign nrBad = go & up & (isI | isS) & ~nrOk;
  assign iAccept = sValid & isI & rxErrorFree & (ns == vr) & ~ownBusy;
  assign iOutSeq = sValid & isI & rxErrorFree & (ns != vr);

  assign busWr = avsWrite & ~avsWaitRequest;
  assign wrCtrl = busWr & (avsAddress == `REG_CTRL);
  // Transmit loads never coincide with a received frame, so the two never fight
  assign canLoad = (~txValid | txReady) & ~rxValid;

  // Register bus: one wait cycle, then the request completes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avsWaitRequest <= 1'b1;
      avsReadData <= 32'h0000_0000;
    end else begin
      avsWaitRequest <= ~(avsWaitRequest & (avsRead | avsWrite));
      if (avsWaitRequest & avsRead) begin
        unique case (avsAddress)
          `REG_CTRL: avsReadData <= {27'h0, ownBusy, uiReq, iReq, discReq, sabmeReq};
          `REG_WINDOW: avsReadData <= {25'h0, kWin};
          `REG_STATUS: avsReadData <= {26'h0, txValid, busyRep, rejCond, peerBusy, mode};
          `REG_VARS: avsReadData <= {9'h0, vr, 1'b0, va, 1'b0, vs};
          `REG_EVENTS: avsReadData <= {26'h0, evt};
          default: avsReadData <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software configuration
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ownBusy <= 1'b0;
      kWin <= `WINDOW_RESET;
    end else begin
      if (wrCtrl) begin
        ownBusy <= avsWriteData[`CTRL_BUSY];
      end
      if (busWr & (avsAddress == `REG_WINDOW)) begin
        kWin <= avsWriteData[6:0];
      end
    end
  end

  // Transmit priority
  always_comb begin
    nextKind = TX_NONE;
    if (uaPend) begin
      nextKind = TX_UA;
    end else if (rejPend) begin
      nextKind = TX_REJ;
    end else if (ackPend) begin
      nextKind = TX_ACK;
    end else if (sabmeReq & (mode != LINK_RELEASE)) begin
      nextKind = TX_SABME;
    end else if (discReq & up) begin
      nextKind = TX_DISC;
    end else if (iReq & up & ~peerBusy & (outOff < kWin)) begin
      nextKind = TX_IFRAME;
    end else if (uiReq) begin
      nextKind = TX_UI;
    end
  end

  // Sequence state variables
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vs <= 7'h00;
      va <= 7'h00;
      vr <= 7'h00;
    end else if (go) begin
      if (sSabme | (uUa & (mode == LINK_SETUP))) begin
        vs <= 7'h00;
        va <= 7'h00;
        vr <= 7'h00;
      end else if (sDisc) begin
        va <= vs;
      end else if (sValid) begin
        va <= nr;
        if (rxOctet4 == `CF_REJ) begin
          vs <= nr;
        end
        if (iAccept) begin
          vr <= vr + 7'h01;
        end
      end
    end else if (canLoad & (nextKind == TX_IFRAME)) begin
      vs <= vs + 7'h01;
    end else if (canLoad & (nextKind == TX_DISC)) begin
      va <= vs;
    end
  end

  // Link mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode <= LINK_DOWN;
    end else if (go) begin
      if (sSabme) begin
        mode <= LINK_UP;
      end else if (sDisc) begin
        mode <= LINK_DOWN;
      end else if (mode == LINK_SETUP & (uUa | uDm)) begin
        mode <= uUa ? LINK_UP : LINK_DOWN;
      end else if (mode == LINK_RELEASE & (uUa | uDm)) begin
        // release ends on UA or DM
        mode <= LINK_DOWN;
      end
    end else if (canLoad & (nextKind == TX_SABME)) begin
      mode <= LINK_SETUP;
    end else if (canLoad & (nextKind == TX_DISC)) begin
      mode <= LINK_RELEASE;
    end
  end

  // Exception conditions
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      peerBusy <= 1'b0;
      rejCond <= 1'b0;
      rejNr <= 7'h00;
      busyRep <= 1'b0;
    end else if (go) begin
      if (sSabme | sDisc) begin
        peerBusy <= 1'b0;
        rejCond <= 1'b0;
      end else if (sValid & isS) begin
        peerBusy <= (rxOctet4 == `CF_RNR);
      end else if (iAccept & rejCond & (ns == rejNr)) begin
        rejCond <= 1'b0;
      end else if (iOutSeq & ~rejCond & ~ownBusy) begin
        rejCond <= 1'b1;
        rejNr <= vr;
      end
    end else if (canLoad) begin
      unique case (nextKind)
        TX_SABME: begin
          peerBusy <= 1'b0;
          rejCond <= 1'b0;
          busyRep <= 1'b0;
        end
        // REJ or UA clears reported busy
        TX_REJ, TX_UA: busyRep <= 1'b0;
        TX_ACK: busyRep <= ownBusy;
        default: busyRep <= busyRep;
      endcase
    end
  end

  // Pending transmit work
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      uaPend <= 1'b0;
      uaF <= 1'b0;
      ackPend <= 1'b0;
      ackF <= 1'b0;
      rejPend <= 1'b0;
      sabmeReq <= 1'b0;
      discReq <= 1'b0;
      iReq <= 1'b0;
      uiReq <= 1'b0;
    end else begin
      if (go) begin
        if (sSabme | sDisc) begin
          uaPend <= 1'b1;
          uaF <= pf;
          ackPend <= 1'b0;
          rejPend <= 1'b0;
          iReq <= 1'b0;
        end else if (sValid & isS & rxCommand & rxOctet5[0]) begin
          ackPend <= 1'b1;
          ackF <= 1'b1;
        end else if (iAccept) begin
          ackPend <= 1'b1;
          ackF <= rxOctet5[0];
          // no REJ once the gap is filled
          rejPend <= rejPend & ~(rejCond & (ns == rejNr));
        end else if (iOutSeq & ~rejCond & ~ownBusy) begin
          rejPend <= 1'b1;
        end
      end else if (canLoad) begin
        unique case (nextKind)
          TX_UA: uaPend <= 1'b0;
          TX_REJ: rejPend <= 1'b0;
          TX_ACK: ackPend <= 1'b0;
          TX_SABME: sabmeReq <= 1'b0;
          TX_DISC: discReq <= 1'b0;
          TX_IFRAME: begin
            iReq <= 1'b0;
            ackPend <= ackPend & ackF;
          end
          TX_UI: uiReq <= 1'b0;
          default: uaPend <= uaPend;
        endcase
      end
      if (wrCtrl) begin
        if (avsWriteData[`CTRL_SABME]) sabmeReq <= 1'b1;
        if (avsWriteData[`CTRL_DISC]) discReq <= 1'b1;
        if (avsWriteData[`CTRL_IFRAME]) iReq <= 1'b1;
        if (avsWriteData[`CTRL_UI]) uiReq <= 1'b1;
      end
    end
  end

  // Outgoing control field
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txValid <= 1'b0;
      txOctet4 <= 8'h00;
      txOctet5 <= 8'h00;
      txTwoOctet <= 1'b0;
      txCommand <= 1'b0;
    end else if (canLoad) begin
      txValid <= (nextKind != TX_NONE);
      txTwoOctet <= 1'b0;
      txOctet5 <= 8'h00;
      unique case (nextKind)
        TX_UA: begin
          txOctet4 <= `CF_UA | (uaF ? `PF_SET : 8'h00);
          txCommand <= 1'b0;
        end
        TX_REJ: begin
          txOctet4 <= `CF_REJ;
          txOctet5 <= {vr, 1'b0};
          txTwoOctet <= 1'b1;
          txCommand <= 1'b0;
        end
        TX_ACK: begin
          txOctet4 <= ownBusy ? `CF_RNR : `CF_RR;
          txOctet5 <= {vr, ackF};
          txTwoOctet <= 1'b1;
          txCommand <= 1'b0;
        end
        TX_SABME: begin
          txOctet4 <= `CF_SABME | `PF_SET;
          txCommand <= 1'b1;
        end
        TX_DISC: begin
          txOctet4 <= `CF_DISC | `PF_SET;
          txCommand <= 1'b1;
        end
        TX_IFRAME: begin
          txOctet4 <= {vs, 1'b0};
          txOctet5 <= {vr, 1'b0};
          txTwoOctet <= 1'b1;
          txCommand <= 1'b1;
        end
        TX_UI: begin
          txOctet4 <= `CF_UI;
          txCommand <= 1'b1;
        end
        default: begin
          txOctet4 <= 8'h00;
          txCommand <= 1'b0;
        end
      endcase
    end
  end

  // Sticky events, write one to clear; a new event wins over its clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evt <= '0;
      iDeliver <= 1'b0;
    end else begin
      evt <= (evt & ~((busWr & (avsAddress == `REG_EVENTS)) ?
             avsWriteData[`EVT_WIDTH-1:0] : {`EVT_WIDTH{1'b0}}))
             | {iAccept, go & uFrmr, go & uXid, go & uUi, nrBad, undef};
      iDeliver <= iAccept;
    end
  end

  sabme_reset_a:
    assert property (@(posedge ref_clk) disable iff (rst)
      go & sSabme |=> vs == 7'h00 && va == 7'h00 && vr == 7'h00 && mode == LINK_UP)
    else $error("SABME did not zero variables");
  ua_first_a:
    assert property (@(posedge ref_clk) disable iff (rst)
      uaPend & canLoad |=> txValid && (txOctet4 & `CF_PF_MASK) == `CF_UA)
    else $error("UA not sent first");
  ui_stable_a:
    assert property (@(posedge ref_clk) disable iff (rst)
      go & uUi |=> vs == $past(vs) && va == $past(va) && vr == $past(vr))
    else $error("UI changed a variable");
  drop_app_a:
    assert property (@(posedge ref_clk) disable iff (rst)
      rxValid & ~rxAppKnown |=> $stable(mode) && vr == $past(vr) && va == $past(va))
    else $error("Dropped frame changed state");
  undef_flag_a:
    assert property (@(posedge ref_clk) disable iff (rst)
      undef |=> evt[0])
    else $error("Undefined field not flagged");
  rej_clear_a:
    assert property (@(posedge ref_clk) disable iff (rst)
      iAccept & rejCond & (ns == rejNr) |=> ~rejCond ##1 ~rejPend || rejCond)
    else $error("REJ condition kept");
  vs_step_a:
    assert property (@(posedge ref_clk) disable iff (rst)
      canLoad & (nextKind == TX_IFRAME) |=> vs == $past(vs) + 7'h01 && txOctet4[7:1] == $past(vs))
    else $error("V(S) did not step");
  disc_hold_a:
    assert property (@(posedge ref_clk) disable iff (rst)
      mode == LINK_RELEASE && !(go && (uUa || uDm || sSabme || sDisc)) |=> mode == LINK_RELEASE)
    else $error("Release ended early");
  va_update_a:
    assert property (@(posedge ref_clk) disable iff (rst)
      sValid & ~iAccept & ~(isS & rxOctet4 == `CF_REJ) |=> va == $past(nr))
    else $error("V(A) not updated");
  vr_step_a:
    assert property (@(posedge ref_clk) disable iff (rst)
      iAccept |=> vr == $past(vr) + 7'h01 && iDeliver)
    else $error("V(R) did not step");
  sabme_clear_a:
    assert property (@(posedge ref_clk) disable iff (rst)
      canLoad & (nextKind == TX_SABME) |=> ~rejCond && ~busyRep && ~peerBusy)
    else $error("SABME kept exceptions");
  rej_busy_a:
    assert property (@(posedge ref_clk) disable iff (rst)
      canLoad & (nextKind == TX_REJ) |=> ~busyRep && txOctet4 == `CF_REJ)
    else $error("REJ kept busy");
endmodule // lapd_frame_control

// *** rtl/lapd_pkg.sv ***
/*
  Types shared by the link control block.
  Assumes the constants header sits beside it.
*/
package lapd_pkg;
  `include "lapd_defs.svh"

  typedef logic [6:0] seq_t;

  typedef enum logic [1:0] {
    LINK_DOWN = 2'b00,
    LINK_SETUP = 2'b01,
    LINK_UP = 2'b11,
    LINK_RELEASE = 2'b10
  } link_mode_t;

  typedef enum logic [2:0] {
    TX_NONE, TX_UA, TX_REJ, TX_ACK, TX_SABME, TX_DISC, TX_IFRAME, TX_UI
  } tx_kind_t;
endpackage

// *** verification/peer_entity.sv ***
/*
  Far-side link entity model: sends control fields into the block and takes
  the fields it offers, at once or with stalls.
  Assumes its send task is called just after a rising edge of ref_clk.
*/
`timescale 1ns/1ns
module peer_entity (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic txValid,
  input wire logic [7:0] txOctet4,
  input wire logic [7:0] txOctet5,
  input wire logic txTwoOctet,
  input wire logic txCommand,
  output logic txReady,
  output logic rxValid,
  output logic [7:0] rxOctet4,
  output logic [7:0] rxOctet5,
  output logic rxCommand,
  output logic rxHasInfo,
  output logic rxAppKnown,
  output logic rxErrorFree
);
  logic [17:0] log [0:63];
  logic [1:0] phase;
  int count = 0;

  initial begin
    rxValid = 1'b0;
    rxOctet4 = 8'h00;
    rxOctet5 = 8'h00;
    rxCommand = 1'b0;
    rxHasInfo = 1'b0;
    rxAppKnown = 1'b1;
    rxErrorFree = 1'b1;
  end

  // Stalls: ready one cycle in four when slow
  always @(posedge ref_clk or posedge rst) begin
    if (rst) phase <= 2'h0;
    else phase <= phase + 2'h1;
  end
  assign txReady = !slow || (phase == 2'h3);

  always @(posedge ref_clk) begin
    if (txValid && txReady) begin
      log[count] <= {txCommand, txTwoOctet, txOctet4, txOctet5};
      count <= count + 1;
    end
  end

  // Info and quality flags stand until changed
  task automatic flags(input logic info, input logic ok);
    rxHasInfo <= info;
    rxErrorFree <= ok;
  endtask

  task automatic send(input logic [7:0] o4, input logic [7:0] o5, input logic cmd,
                      input logic app);
    rxValid <= 1'b1;
    rxOctet4 <= o4;
    rxOctet5 <= o5;
    rxCommand <= cmd;
    rxAppKnown <= app;
    @(posedge ref_clk);
    rxValid <= 1'b0;
    rxOctet4 <= ~o4;
    rxOctet5 <= ~o5;
    rxCommand <= ~cmd;
    rxAppKnown <= ~app;
  endtask
endmodule // peer_entity

// *** verification/testbench.sv ***
/*
  Self-checking bench for the link control block and its peer model.
  Assumes the package and the constants header are compiled first.
*/
`timescale 1ns/1ns
`include "lapd_defs.svh"
`define CHECK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    numErrors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avsAddress = 8'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h00000000;
  logic slow = 1'b0;
  logic [31:0] avsReadData, rdData;
  logic avsWaitRequest, txValid, txTwoOctet, txCommand, txReady, iDeliver;
  logic rxValid, rxCommand, rxHasInfo, rxAppKnown, rxErrorFree;
  logic [7:0] rxOctet4, rxOctet5, txOctet4, txOctet5;
  int numErrors = 0;
  int checks = 0;
  int delivered = 0;
  int base = 0;

  lapd_frame_control u_dut (.ref_clk, .rst, .avsAddress, .avsRead, .avsWrite,
    .avsWriteData, .avsReadData, .avsWaitRequest, .rxValid, .rxOctet4, .rxOctet5,
    .rxCommand, .rxHasInfo, .rxAppKnown, .rxErrorFree, .txValid, .txOctet4,
    .txOctet5, .txTwoOctet, .txCommand, .txReady, .iDeliver);
  peer_entity u_peer (.ref_clk, .rst, .slow, .txValid, .txOctet4, .txOctet5,
    .txTwoOctet, .txCommand, .txReady, .rxValid, .rxOctet4, .rxOctet5, .rxCommand,
    .rxHasInfo, .rxAppKnown, .rxErrorFree);

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (iDeliver === 1'b1) delivered++;
  end

  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge ref_clk);
    avsAddress <= addr;
    avsWriteData <= wdata;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    if (avsWaitRequest !== 1'b0) numErrors++;
    rdData = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] addr);
    xfer(1'b0, addr, 32'h00000000);
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    xfer(1'b1, addr, data);
  endtask
  task automatic rx(input logic [7:0] o4, input logic [7:0] o5, input logic cmd,
                    input logic app);
    base = u_peer.count;
    @(posedge ref_clk);
    u_peer.send(o4, o5, cmd, app);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic txChk(input int idx, input logic [9:0] exp, input logic [7:0] mask);
    int n;
    n = 0;
    while (u_peer.count <= idx && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (u_peer.count <= idx) numErrors++;
    `CHECK(u_peer.log[idx][17:8] & {2'b11, mask}, exp)
  endtask
  task automatic vars(input logic [6:0] vs, input logic [6:0] va, input logic [6:0] vr);
    rd(`REG_VARS);
    `CHECK({rdData[22:16], rdData[14:8], rdData[6:0]}, {vr, va, vs})
  endtask
  task automatic mode(input logic [1:0] m);
    rd(`REG_STATUS);
    `CHECK(rdData[1:0], m)
  endtask

  task automatic testReset();
    rd(`REG_WINDOW);
    `CHECK(rdData, 32'h00000007)
    rd(8'h14);
    `CHECK(rdData, 32'h00000000)
    mode(2'h0);
    rx(8'h00, 8'h01, 1'b1, 1'b1);
    vars(7'h00, 7'h00, 7'h00);
    `CHECK(u_peer.count, 0)
    $display("reset test done");
  endtask
  task automatic testSetup();
    rx(`CF_SABME | `PF_SET, 8'h00, 1'b1, 1'b1);
    txChk(base, {2'b00, `CF_UA | `PF_SET}, 8'hFF);
    mode(2'h3);
    $display("setup test done");
  endtask
  task automatic testWindow();
    slow <= 1'b1;
    wr(`REG_WINDOW, 32'h00000002);
    base = u_peer.count;
    for (int i = 0; i < 2; i++) begin
      wr(`REG_CTRL, 32'h00000004);
      txChk(base + i, {2'b11, 7'(i), 1'b0}, 8'hFF);
      `CHECK(u_peer.log[base + i][7:1], 7'h00)
    end
    wr(`REG_CTRL, 32'h00000004);
    repeat (20) @(posedge ref_clk);
    `CHECK(u_peer.count, base + 2)
    rx(`CF_RR, 8'h04, 1'b0, 1'b1);
    txChk(base, {2'b11, 8'h04}, 8'hFF);
    vars(7'h03, 7'h02, 7'h00);
    rx(`CF_RR, 8'h0A, 1'b0, 1'b1);
    rd(`REG_EVENTS);
    `CHECK(rdData[1], 1'b1)
    vars(7'h03, 7'h02, 7'h00);
    wr(`REG_EVENTS, 32'h0000003F);
    rd(`REG_EVENTS);
    `CHECK(rdData[5:0], 6'h00)
    slow <= 1'b0;
    $display("window test done");
  endtask
  task automatic testReceive();
    rx(8'h00, 8'h05, 1'b1, 1'b1);
    txChk(base, {2'b01, `CF_RR}, 8'hFF);
    `CHECK(u_peer.log[base][7:0], 8'h03)
    `CHECK(delivered, 1)
    rx(8'h0A, 8'h04, 1'b1, 1'b1);
    txChk(base, {2'b01, `CF_REJ}, 8'hFF);
    `CHECK(u_peer.log[base][7:1], 7'h01)
    rd(`REG_STATUS);
    `CHECK(rdData[3], 1'b1)
    rx(8'h0C, 8'h04, 1'b1, 1'b1);
    `CHECK(u_peer.count, base)
    rx(8'h02, 8'h04, 1'b1, 1'b1);
    rd(`REG_STATUS);
    `CHECK(rdData[3], 1'b0)
    vars(7'h03, 7'h02, 7'h02);
    $display("receive test done");
  endtask
  task automatic testBusy();
    wr(`REG_CTRL, 32'h00000010);
    rx(`CF_RR, 8'h05, 1'b1, 1'b1);
    txChk(base, {2'b01, `CF_RNR}, 8'hFF);
    `CHECK(u_peer.log[base][7:0], 8'h05)
    wr(`REG_CTRL, 32'h00000000);
    rx(`CF_REJ, 8'h05, 1'b1, 1'b1);
    txChk(base, {2'b01, `CF_RR}, 8'hFF);
    vars(7'h02, 7'h02, 7'h02);
    $display("busy test done");
  endtask
  task automatic testEvents();
    rx(`CF_DISC | `PF_SET, 8'h00, 1'b1, 1'b0);
    `CHECK(u_peer.count, base)
    rx(8'hFF, 8'h00, 1'b1, 1'b1);
    rx(`CF_UI, 8'h00, 1'b1, 1'b1);
    rx(`CF_XID, 8'h00, 1'b1, 1'b1);
    mode(2'h3);
    rd(`REG_EVENTS);
    `CHECK(rdData[3:0], 4'hD)
    vars(7'h02, 7'h02, 7'h02);
    $display("event test done");
  endtask
  task automatic testQuality();
    u_peer.flags(1'b0, 1'b0);
    rx(8'h04, 8'h04, 1'b1, 1'b1);
    `CHECK(u_peer.count, base)
    `CHECK(delivered, 2)
    wr(`REG_EVENTS, 32'h0000003F);
    u_peer.flags(1'b1, 1'b1);
    rx(`CF_SABME | `PF_SET, 8'h00, 1'b1, 1'b1);
    u_peer.flags(1'b0, 1'b1);
    rx(`CF_FRMR, 8'h00, 1'b0, 1'b1);
    mode(2'h3);
    rd(`REG_EVENTS);
    `CHECK(rdData[5:0], 6'h11)
    rx(8'h04, 8'h04, 1'b1, 1'b1);
    txChk(base, {2'b01, `CF_RR}, 8'hFF);
    `CHECK(u_peer.log[base][7:0], 8'h06)
    rd(`REG_EVENTS);
    `CHECK(rdData[5], 1'b1)
    base = u_peer.count;
    wr(`REG_CTRL, 32'h00000008);
    txChk(base, {2'b10, `CF_UI}, 8'hFF);
    vars(7'h02, 7'h02, 7'h03);
    $display("quality test done");
  endtask
  task automatic testModes();
    rx(`CF_DISC | `PF_SET, 8'h00, 1'b1, 1'b1);
    txChk(base, {2'b00, `CF_UA | `PF_SET}, 8'hFF);
    mode(2'h0);
    base = u_peer.count;
    wr(`REG_CTRL, 32'h00000001);
    txChk(base, {2'b10, `CF_SABME}, `CF_PF_MASK);
    rx(`CF_UA | `PF_SET, 8'h00, 1'b0, 1'b1);
    mode(2'h3);
    `CHECK(rdData[4:2], 3'h0)
    vars(7'h00, 7'h00, 7'h00);
    base = u_peer.count;
    wr(`REG_CTRL, 32'h00000002);
    txChk(base, {2'b10, `CF_DISC}, `CF_PF_MASK);
    rx(`CF_RR, 8'h00, 1'b0, 1'b1);
    mode(2'h2);
    rx(`CF_DM | `PF_SET, 8'h00, 1'b0, 1'b1);
    mode(2'h0);
    $display("mode test done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    testReset();
    testSetup();
    testWindow();
    testReceive();
    testBusy();
    testEvents();
    testQuality();
    testModes();
    conclude();
  end
  initial begin
    #100000;
    numErrors++;
    conclude();
  end
endmodule // testbench
